// ==== common/sli_pkg.sv ====
// Register map, field layout and link constants of the serial link interrupt logic
package sli_pkg;
  // Register byte offsets
  localparam logic [7:0] SLI_OFF_CTRL = 8'h04;
  localparam logic [7:0] SLI_OFF_STAT = 8'h08;
  localparam logic [7:0] SLI_OFF_PRIO = 8'h0c;
  localparam logic [7:0] SLI_OFF_STATCLR = 8'h10;
  localparam logic [7:0] SLI_OFF_PENDSET = 8'h14;
  localparam logic [7:0] SLI_OFF_PTR = 8'h18;
  localparam logic [7:0] SLI_OFF_MASK = 8'h48;
  // Control register fields
  localparam int SLI_CTRL_LOCAL = 14;
  localparam int SLI_CTRL_ERRIEN = 13;
  localparam int SLI_CTRL_VEC_HI = 12;
  localparam int SLI_CTRL_VEC_LO = 8;
  localparam int SLI_CTRL_PTRLOC = 7;
  // Status register fields
  localparam int SLI_STAT_LINK = 0;
  localparam int SLI_STAT_LERR = 8;
  localparam int SLI_STAT_RERR = 9;
  // Priority vector register: flag set while nothing is pending
  localparam int SLI_PRIO_NONE = 31;
  // Reset values
  localparam logic [31:0] SLI_RST_WORD = 32'h0000_0000;
  localparam logic [4:0] SLI_RST_VEC = 5'h00;
  // Interrupt packet length in link bits, pointer value that targets the pending register
  localparam logic [5:0] SLI_PKT_BITS = 6'h20;
  localparam logic [31:0] SLI_PTR_PENDSET = 32'h0000_0014;
  // AHB constants
  localparam logic [1:0] SLI_HTRANS_NONSEQ = 2'h2;
endpackage

// ==== hw/sli_top.sv ====
// Interrupt generation and forwarding logic of a chip-to-chip serial link port
//
// Overview of operation
// - Pending register bits set by software write, remote packet, or link error.
// - Remote mode with pending bits nonzero: send them as an interrupt packet.
// - Remote mode: clear the pending bits carried once their packet is sent.
// - Local mode: move set pending bits into the status/clear register.
// - CPU interrupt line comes from the OR of all status/clear bits, pulsed.
// - Status/clear write while interrupts remain pending gives a new pulse.
// - Priority vector reports lowest-numbered set bit; bit 0 highest priority.
// - Reading returns the top vector; writing it back clears that one interrupt.
// - Priority vector register has read-only flag: nothing pending in status/clear.
// - Received interrupt packet status goes to the pending register when the pointer holds its offset.
// - Pointer-target bit 1 sends received interrupt writes to local registers.
// - Remote error flag on remote-reported bad packet; local error on bad inbound.
// - Error flag set with error interrupt enabled posts pending bit at vector.
// - Remote error flag set each time the link comes up; write 1 clears it.
// - No reaction to debug halt; operation continues while CPU halted.
//
// Chosen here: register access over AHB-Lite.
module sli_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial link pins
  input wire logic link_clk,
  input wire logic link_rx_frame,
  input wire logic link_rx_data,
  input wire logic link_remote_err,
  input wire logic link_up,
  output logic link_tx_frame,
  output logic link_tx_data,
  // Interrupt outputs
  output logic link_cpu_irq,
  output logic link_irq_output
);
  import sli_pkg::*;

  typedef struct packed {
    // Bus data phase
    logic dp_wr;
    logic dp_rd;
    logic rd_done;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    // Software visible state
    logic ctrl_local;
    logic ctrl_errien;
    logic [4:0] ctrl_vec;
    logic ctrl_ptrloc;
    logic [31:0] ptr;
    logic [31:0] pending;
    logic [31:0] statclr;
    logic [31:0] mask;
    logic lerr;
    logic rerr;
    // Pin synchronisers and edge history
    logic [1:0] clk_s;
    logic clk_d;
    logic [1:0] frm_s;
    logic [1:0] dat_s;
    logic [1:0] rem_s;
    logic rem_d;
    logic [1:0] up_s;
    logic up_d;
    // Transmit engine
    logic tx_active;
    logic [5:0] tx_cnt;
    logic [31:0] tx_bits;
    logic [31:0] tx_shift;
    logic tx_frame;
    logic tx_data;
    // Receive engine
    logic rx_busy;
    logic [5:0] rx_cnt;
    logic [31:0] rx_shift;
    // CPU interrupt pulse
    logic any_stat;
    logic irq_pulse;
  } sli_state_t;

  sli_state_t st_reg;
  sli_state_t st_next;

  logic addr_ok;
  logic wr_ok;
  logic lclk_rise;
  logic lclk_fall;
  logic rx_end;
  logic rx_good;
  logic rerr_set;
  logic lerr_set;
  logic [4:0] prio_vec;
  logic prio_none;
  logic [31:0] rd_mux;
  logic [31:0] pend_set;
  logic [31:0] pend_clr;
  logic [31:0] stat_set;
  logic [31:0] stat_clr;
  logic stat_wr;

  // Lowest set status bit wins; bit 0 is the most urgent
  always_comb begin
    prio_vec = SLI_RST_VEC;
    prio_none = (st_reg.statclr == SLI_RST_WORD);
    for (int i = 31; i >= 0; i--) begin
      if (st_reg.statclr[i]) begin
        prio_vec = 5'(i);
      end
    end
  end

  // Read multiplexer, sampled into a flop in the wait state of each read
  always_comb begin
    rd_mux = SLI_RST_WORD;
    unique case (st_reg.dp_addr)
      SLI_OFF_CTRL: begin
        rd_mux[SLI_CTRL_LOCAL] = st_reg.ctrl_local;
        rd_mux[SLI_CTRL_ERRIEN] = st_reg.ctrl_errien;
        rd_mux[SLI_CTRL_VEC_HI:SLI_CTRL_VEC_LO] = st_reg.ctrl_vec;
        rd_mux[SLI_CTRL_PTRLOC] = st_reg.ctrl_ptrloc;
      end
      SLI_OFF_STAT: begin
        rd_mux[SLI_STAT_LINK] = st_reg.up_s[1];
        rd_mux[SLI_STAT_LERR] = st_reg.lerr;
        rd_mux[SLI_STAT_RERR] = st_reg.rerr;
      end
      SLI_OFF_PRIO: begin
        rd_mux[4:0] = prio_vec;
        rd_mux[SLI_PRIO_NONE] = prio_none;
      end
      SLI_OFF_STATCLR: rd_mux = st_reg.statclr;
      SLI_OFF_PENDSET: rd_mux = st_reg.pending;
      SLI_OFF_PTR: rd_mux = st_reg.ptr;
      SLI_OFF_MASK: rd_mux = st_reg.mask;
      default: rd_mux = SLI_RST_WORD; // Unmapped words read as zero
    endcase
  end

  // Edges of the synchronised link clock; only the second flop is looked at
  assign lclk_rise = st_reg.clk_s[1] & ~st_reg.clk_d;
  assign lclk_fall = ~st_reg.clk_s[1] & st_reg.clk_d;
  // Frame end seen on a link clock rising edge; a packet of other length is bad
  assign rx_end = lclk_rise & st_reg.rx_busy & ~st_reg.frm_s[1];
  assign rx_good = rx_end & (st_reg.rx_cnt == SLI_PKT_BITS);
  assign lerr_set = rx_end & (st_reg.rx_cnt != SLI_PKT_BITS);
  // Remote error on a reported bad packet and each time the link comes up
  assign rerr_set = (st_reg.rem_s[1] & ~st_reg.rem_d) | (st_reg.up_s[1] & ~st_reg.up_d);
  assign addr_ok = hsel & hready & (htrans == SLI_HTRANS_NONSEQ);
  assign wr_ok = st_reg.dp_wr;
  assign stat_wr = wr_ok & (st_reg.dp_addr == SLI_OFF_STATCLR);

  // Next-state logic for the whole block. No debug halt input exists:
  // the link and the interrupt path keep running while the CPU is stopped.
  always_comb begin
    st_next = st_reg;
    pend_set = SLI_RST_WORD;
    pend_clr = SLI_RST_WORD;
    stat_set = SLI_RST_WORD;
    stat_clr = SLI_RST_WORD;

    // Bus: one wait state on reads keeps read data registered and fresh
    st_next.dp_wr = addr_ok & hwrite;
    st_next.dp_rd = addr_ok & ~hwrite;
    st_next.rd_done = 1'b0;
    if (addr_ok) begin
      st_next.dp_addr = {haddr[7:2], 2'b00};
    end
    if (st_reg.dp_rd & ~st_reg.rd_done) begin
      st_next.rdata = rd_mux;
      st_next.rd_done = 1'b1;
      st_next.dp_rd = 1'b1;
      st_next.dp_addr = st_reg.dp_addr;
    end

    // Register writes in the data phase
    if (wr_ok) begin
      unique case (st_reg.dp_addr)
        SLI_OFF_CTRL: begin
          st_next.ctrl_local = hwdata[SLI_CTRL_LOCAL];
          st_next.ctrl_errien = hwdata[SLI_CTRL_ERRIEN];
          st_next.ctrl_vec = hwdata[SLI_CTRL_VEC_HI:SLI_CTRL_VEC_LO];
          st_next.ctrl_ptrloc = hwdata[SLI_CTRL_PTRLOC];
        end
        SLI_OFF_STAT: begin
          if (hwdata[SLI_STAT_LERR]) st_next.lerr = 1'b0;
          if (hwdata[SLI_STAT_RERR]) st_next.rerr = 1'b0;
        end
        SLI_OFF_PRIO: begin
          // Only the current top vector clears; a stale vector does nothing
          if (!prio_none && hwdata[4:0] == prio_vec) begin
            stat_clr[prio_vec] = 1'b1;
          end
        end
        SLI_OFF_STATCLR: stat_clr = hwdata;
        SLI_OFF_PENDSET: pend_set = hwdata;
        SLI_OFF_PTR: st_next.ptr = hwdata;
        SLI_OFF_MASK: st_next.mask = hwdata;
        default: ;
      endcase
    end

    // Error flags: an event in the cycle of a clear wins over the clear
    if (lerr_set) st_next.lerr = 1'b1;
    if (rerr_set) st_next.rerr = 1'b1;
    if (st_reg.ctrl_errien && (lerr_set || rerr_set)) begin
      pend_set[st_reg.ctrl_vec] = 1'b1;
    end

    // Synchronisers and edge history
    st_next.clk_s = {st_reg.clk_s[0], link_clk};
    st_next.clk_d = st_reg.clk_s[1];
    st_next.frm_s = {st_reg.frm_s[0], link_rx_frame};
    st_next.dat_s = {st_reg.dat_s[0], link_rx_data};
    st_next.rem_s = {st_reg.rem_s[0], link_remote_err};
    st_next.rem_d = st_reg.rem_s[1];
    st_next.up_s = {st_reg.up_s[0], link_up};
    st_next.up_d = st_reg.up_s[1];

    // Receive: shift on link clock rising edges while the frame is high
    if (lclk_rise) begin
      if (st_reg.frm_s[1]) begin
        st_next.rx_busy = 1'b1;
        st_next.rx_shift = {st_reg.rx_shift[30:0], st_reg.dat_s[1]};
        if (st_reg.rx_cnt != 6'h3f) st_next.rx_cnt = st_reg.rx_cnt + 6'h01;
      end else begin
        st_next.rx_busy = 1'b0;
        st_next.rx_cnt = 6'h00;
      end
    end
    // Status lands at the pointer address; only the pending register is local here
    if (rx_good && st_reg.ctrl_ptrloc && st_reg.ptr == SLI_PTR_PENDSET) begin
      pend_set = pend_set | st_reg.rx_shift;
    end

    // Transmit: MSB first, bits change on link clock falling edges
    if (lclk_fall) begin
      if (st_reg.tx_active) begin
        if (st_reg.tx_cnt == SLI_PKT_BITS - 6'h01) begin
          st_next.tx_active = 1'b0;
          st_next.tx_frame = 1'b0;
          st_next.tx_data = 1'b0;
          pend_clr = st_reg.tx_bits;
        end else begin
          st_next.tx_cnt = st_reg.tx_cnt + 6'h01;
          st_next.tx_shift = {st_reg.tx_shift[30:0], 1'b0};
          st_next.tx_data = st_reg.tx_shift[30];
        end
      end else if (!st_reg.ctrl_local && st_reg.pending != SLI_RST_WORD) begin
        st_next.tx_active = 1'b1;
        st_next.tx_cnt = 6'h00;
        st_next.tx_bits = st_reg.pending;
        st_next.tx_shift = st_reg.pending;
        st_next.tx_frame = 1'b1;
        st_next.tx_data = st_reg.pending[31];
      end
    end

    // Local mode moves pending bits into status; not while a packet is in flight
    if (st_reg.ctrl_local && !st_reg.tx_active) begin
      stat_set = st_reg.pending;
      pend_clr = pend_clr | st_reg.pending;
    end

    // Sticky registers: set wins over clear
    st_next.pending = (st_reg.pending & ~pend_clr) | pend_set;
    st_next.statclr = (st_reg.statclr & ~stat_clr) | stat_set;

    // One-cycle pulse on a new interrupt, or on a status write leaving work
    st_next.any_stat = |st_next.statclr;
    st_next.irq_pulse = (st_next.any_stat & ~st_reg.any_stat) | (stat_wr & st_next.any_stat);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign hreadyout = ~(st_reg.dp_rd & ~st_reg.rd_done);
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign link_tx_frame = st_reg.tx_frame;
  assign link_tx_data = st_reg.tx_data;
  assign link_cpu_irq = st_reg.irq_pulse;
  assign link_irq_output = |(st_reg.statclr & st_reg.mask);

  // Checks
  AST_PULSE_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
    link_cpu_irq |=> !link_cpu_irq) else $error("irq pulse longer than one cycle");
  AST_PULSE_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(|st_reg.statclr) |-> link_cpu_irq) else $error("no pulse on new status");
  AST_REPULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_wr && (|st_next.statclr) |=> link_cpu_irq) else $error("no pulse on rewrite");
  AST_LOCAL_MOVE: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.ctrl_local && !st_reg.tx_active && (st_reg.pending != 32'h0) && !wr_ok
    |=> ((st_reg.statclr & $past(st_reg.pending)) == $past(st_reg.pending)))
    else $error("pending bits not moved to status");
  AST_TX_START: assert property (@(posedge hclk) disable iff (!hresetn)
    lclk_fall && !st_reg.tx_active && !st_reg.ctrl_local && (st_reg.pending != 32'h0)
    |=> st_reg.tx_active && link_tx_frame) else $error("packet not started");
  AST_NONE_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.dp_rd && st_reg.rd_done && (st_reg.dp_addr == SLI_OFF_PRIO)
    |-> hrdata[SLI_PRIO_NONE] == ($past(st_reg.statclr) == 32'h0))
    else $error("none pending flag wrong");
  AST_ERR_POST: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.ctrl_errien && (lerr_set || rerr_set) && !st_reg.ctrl_local
    |=> st_reg.pending[$past(st_reg.ctrl_vec)]) else $error("error not posted");
  AST_LINK_RERR: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_reg.up_s[1]) |=> st_reg.rerr) else $error("link up did not flag remote error");
  AST_RX_POST: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_good && st_reg.ctrl_ptrloc && (st_reg.ptr == SLI_PTR_PENDSET) && !st_reg.ctrl_local
    |=> ((st_reg.pending & $past(st_reg.rx_shift)) == $past(st_reg.rx_shift)))
    else $error("received status not posted");
  AST_W1S: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ok && (st_reg.dp_addr == SLI_OFF_PENDSET) && !st_reg.ctrl_local
    |=> ((st_reg.pending & $past(hwdata)) == $past(hwdata))) else $error("pending write lost");

  // Transmit path: first bit and clearing of the carried bits
  AST_TX_FIRST_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
    lclk_fall && !st_reg.tx_active && !st_reg.ctrl_local && (st_reg.pending != 32'h0)
    |=> link_tx_data == $past(st_reg.pending[31])) else $error("first bit not msb");
  // New sets in the last cycle of a packet survive, so they are left out of the check
  AST_TX_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    lclk_fall && st_reg.tx_active && (st_reg.tx_cnt == SLI_PKT_BITS - 6'h01)
    |=> ((st_reg.pending & $past(st_reg.tx_bits) & ~$past(pend_set)) == 32'h0))
    else $error("sent bits not cleared");
  // Local routing never launches a packet
  AST_NO_TX_LOCAL: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.ctrl_local && !st_reg.tx_active
    |=> !st_reg.tx_active) else $error("packet started in local mode");

  // Priority vector: the reported bit is set and no lower index is set
  AST_PRIO_VEC: assert property (@(posedge hclk) disable iff (!hresetn)
    !prio_none
    |-> st_reg.statclr[prio_vec] && ((st_reg.statclr & ((32'h1 << prio_vec) - 32'h1)) == 32'h0))
    else $error("priority vector wrong");
  // Writing back the vector clears exactly that bit unless it is pending again
  AST_PRIO_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ok && (st_reg.dp_addr == SLI_OFF_PRIO) && !prio_none && (hwdata[4:0] == prio_vec)
    && !st_reg.pending[prio_vec]
    |=> !st_reg.statclr[$past(prio_vec)]) else $error("vector write did not clear");
  // Status write clears the bits written when nothing new arrives
  AST_STAT_W1C: assert property (@(posedge hclk) disable iff (!hresetn)
    stat_wr && !st_reg.ctrl_local
    |=> ((st_reg.statclr & $past(hwdata)) == 32'h0)) else $error("status clear lost");

  // Error flags follow their events
  AST_LERR_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    lerr_set |=> st_reg.lerr) else $error("local error not flagged");
  AST_RERR_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    rerr_set |=> st_reg.rerr) else $error("remote error not flagged");

  // A read holds the bus for exactly one wait state
  AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.dp_rd && !st_reg.rd_done
    |=> hreadyout) else $error("read wait longer than one cycle");
  // The response is always okay
  AST_RESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.dp_wr || st_reg.dp_rd
    |-> !hresp) else $error("error response given");
endmodule

// ==== tb/sli_link_partner.sv ====
// Far end of the serial link: clock source, packet sender and receiver
module sli_link_partner (
  // Control from the bench
  input wire logic run,
  input wire logic go,
  input wire logic [31:0] send_word,
  input wire logic [5:0] send_len,
  output logic busy,
  // Link pins
  input wire logic tx_frame,
  input wire logic tx_data,
  output logic link_clk,
  output logic rx_frame,
  output logic rx_data,
  // Captured outbound packet
  output logic [31:0] got_word,
  output logic [5:0] got_bits
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    rx_frame = 1'b0;
    rx_data = 1'b0;
    busy = 1'b0;
    got_word = 32'h0;
    got_bits = 6'h0;
  end
  // Clock stands still when idle; a high phase is always finished first
  always begin
    #62.5;
    if (run || link_clk) link_clk = ~link_clk;
  end
  // Packet out, MSB first; a short length makes a faulty packet
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      if (i < send_len) begin
        @(negedge link_clk);
        rx_frame = 1'b1;
        rx_data = send_word[i];
      end
    end
    @(negedge link_clk);
    rx_frame = 1'b0;
    rx_data = ~rx_data; // Released line must not keep its last value
    @(negedge link_clk);
    busy = 1'b0;
  end
  // Capture outbound bits on rising link edges; a new run starts with the clock low
  always @(posedge link_clk or posedge run) begin
    if (link_clk !== 1'b1) begin
      got_bits <= 6'h0;
    end else if (tx_frame === 1'b1) begin
      got_word <= {got_word[30:0], tx_data};
      got_bits <= got_bits + 6'h01;
    end
  end
endmodule

// ==== tb/sli_top_test.sv ====
// Self-checking bench for the serial link interrupt logic
module sli_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sli_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic remote_err = 1'b0;
  logic link_up = 1'b0;
  logic run = 1'b0;
  logic go = 1'b0;
  logic [31:0] send_word = 32'h0;
  logic [5:0] send_len = 6'h0;
  logic irq_q = 1'b0;
  logic wide = 1'b0;
  logic hreadyout, hresp, link_clk, rx_frame, rx_data, tx_frame, tx_data;
  logic cpu_irq, irq_out, busy;
  logic [31:0] hrdata, rdata, got_word;
  logic [5:0] got_bits;
  int miscompares = 0;
  int checks_done = 0;
  int pulses = 0;
  int p0;
  always #4 hclk = ~hclk;
  sli_top sli_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .link_rx_frame(rx_frame), .link_rx_data(rx_data), .link_remote_err(remote_err),
    .link_up(link_up), .link_tx_frame(tx_frame), .link_tx_data(tx_data),
    .link_cpu_irq(cpu_irq), .link_irq_output(irq_out));
  sli_link_partner sli_link_partner_i (.run(run), .go(go), .send_word(send_word),
    .send_len(send_len), .busy(busy), .tx_frame(tx_frame), .tx_data(tx_data),
    .link_clk(link_clk), .rx_frame(rx_frame), .rx_data(rx_data), .got_word(got_word),
    .got_bits(got_bits));
  // Count cpu pulses and flag any that lasts two cycles
  always @(posedge hclk) begin
    irq_q <= cpu_irq;
    if (cpu_irq === 1'b1) pulses <= pulses + 1;
    if (cpu_irq === 1'b1 && irq_q === 1'b1) wide <= 1'b1;
  end
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Hready and read data are taken at the rising edge, before the design's flops update
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) begin
      chk("hready wait", 32'h0, 32'h1);
      wrap_up();
    end
    rdata = hrdata;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= SLI_HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(a, 1'b0, 32'h0);
    chk(what, exp, rdata);
  endtask
  task automatic send(input logic [31:0] w, input logic [5:0] n);
    int k;
    send_word <= w;
    send_len <= n;
    go <= 1'b1;
    cyc(2);
    go <= 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      k++;
      cyc(1);
    end
    if (k >= 3000) begin
      chk("link send", 32'h0, 32'h1);
      wrap_up();
    end
    cyc(8);
  endtask
  task automatic t_reset;
    rd(SLI_OFF_CTRL, SLI_RST_WORD, "ctrl");
    rd(SLI_OFF_STATCLR, SLI_RST_WORD, "statclr");
    rd(SLI_OFF_PRIO, 32'h8000_0000, "prio idle");
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
  endtask
  task automatic t_local;
    wr(SLI_OFF_CTRL, 32'h0000_4000);
    p0 = pulses;
    wr(SLI_OFF_PENDSET, 32'h0000_0012);
    cyc(4);
    chk("pulse on set", p0 + 1, pulses);
    rd(SLI_OFF_STATCLR, 32'h0000_0012, "moved");
    rd(SLI_OFF_PENDSET, 32'h0, "pend empty");
    rd(SLI_OFF_PRIO, 32'h0000_0001, "prio");
    wr(SLI_OFF_PRIO, 32'h0000_0001);
    rd(SLI_OFF_STATCLR, 32'h0000_0010, "one cleared");
    rd(SLI_OFF_PRIO, 32'h0000_0004, "prio next");
    p0 = pulses;
    wr(SLI_OFF_STATCLR, 32'h0);
    cyc(4);
    chk("repulse", p0 + 1, pulses);
    wr(SLI_OFF_MASK, 32'h0000_0010);
    cyc(1);
    chk("irq level", 32'h1, {31'h0, irq_out});
    wr(SLI_OFF_MASK, 32'h0);
    cyc(1);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    wr(SLI_OFF_STATCLR, 32'h0000_0010);
    rd(SLI_OFF_PRIO, 32'h8000_0000, "none pend");
    chk("pulse width", 32'h0, {31'h0, wide});
    $display("test local done");
  endtask
  task automatic t_tx;
    int k;
    wr(SLI_OFF_CTRL, 32'h0);
    run <= 1'b1;
    wr(SLI_OFF_PENDSET, 32'h0000_00a5);
    k = 0;
    while (!(got_bits === 6'h20 && tx_frame === 1'b0) && k < 3000) begin
      k++;
      cyc(1);
    end
    if (k >= 3000) begin
      chk("tx wait", 32'h0, 32'h1);
      wrap_up();
    end
    cyc(4);
    chk("tx word", 32'h0000_00a5, got_word);
    chk("tx bits", 32'h20, {26'h0, got_bits});
    rd(SLI_OFF_PENDSET, 32'h0, "sent cleared");
    run <= 1'b0;
    $display("test tx done");
  endtask
  task automatic t_rx;
    wr(SLI_OFF_PTR, SLI_PTR_PENDSET);
    wr(SLI_OFF_CTRL, 32'h0000_6580);
    run <= 1'b1;
    send(32'h0000_0300, 6'h20);
    rd(SLI_OFF_STATCLR, 32'h0000_0300, "remote irq");
    wr(SLI_OFF_STATCLR, 32'h0000_0300);
    send(32'h0000_abcd, 6'h10);
    rd(SLI_OFF_STAT, 32'h0000_0100, "local err");
    rd(SLI_OFF_STATCLR, 32'h0000_0020, "err vector");
    wr(SLI_OFF_STAT, 32'h0000_0100);
    wr(SLI_OFF_STATCLR, 32'h0000_0020);
    run <= 1'b0;
    $display("test rx done");
  endtask
  task automatic t_err;
    wr(SLI_OFF_CTRL, 32'h0000_4000);
    link_up <= 1'b1;
    cyc(8);
    rd(SLI_OFF_STAT, 32'h0000_0201, "link err");
    wr(SLI_OFF_STAT, 32'h0000_0200);
    rd(SLI_OFF_STAT, 32'h0000_0001, "err cleared");
    remote_err <= 1'b1;
    cyc(8);
    remote_err <= 1'b0;
    rd(SLI_OFF_STAT, 32'h0000_0201, "remote err");
    rd(SLI_OFF_STATCLR, 32'h0, "err irq off");
    $display("test err done");
  endtask
  initial begin
    cyc(5);
    hresetn <= 1'b1;
    t_reset();
    t_local();
    t_tx();
    t_rx();
    t_err();
    wrap_up();
  end
endmodule
